// ### csr_special_regs.sv
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - bank bit picks jump/call program bank
// - bank register bits 7..1 read zero
// - low pc write jumps in page, dummy cycle
// - table read: high byte latched, low delivered
// - 55h then aah consecutively enables mapping
// - mapped last page c0..ff reads option memory
// - mapping ends after four slow oscillator periods
// - each new pattern restarts the mapping timer
// - wake from idle or sleep clears unlock
// - status writes keep timeout and power-down flags
// - carry from add, no borrow, rotates
// - half carry from low nibble
// - zero flag on zero result
// - overflow when msb carries in xor out
// - power-down: cleared clear-wdt/reset, set halt
// - timeout: cleared reset/clear/halt, set by watchdog
// - signed flag is overflow xor result msb
// - status never saved automatically
// - no direct register-to-register path
module csr_special_regs
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core events
  input  wire logic              alu_valid,
  input  wire csr_alu_op_t       alu_op,
  input  wire logic [7:0]        alu_a,
  input  wire logic [7:0]        alu_b,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              halt_instr,
  input  wire logic              watchdog_timeout,
  input  wire logic              wake_event,
  input  wire logic              lirc_tick,
  // branch target
  input  wire logic              branch_req,
  input  wire logic [12:0]       branch_addr,
  output logic                   branch_valid,
  output logic      [13:0]       branch_target,
  output logic                   program_bank_select,
  // low pc jump
  output logic                   pc_load,
  output logic      [7:0]        pc_load_target,
  output logic                   pc_dummy,
  // table read
  input  wire logic              table_read_instr,
  input  wire logic              table_read_last_page,
  input  wire logic [15:0]       fetch_data,
  output logic                   fetch_req,
  output logic                   fetch_option,
  output logic      [15:0]       fetch_addr,
  output logic                   table_low_valid,
  output logic      [7:0]        table_low_data,
  // state
  output logic                   option_map_active,
  output logic      [7:0]        status_flags
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  pc_low_byte;       // last value written to low pc
  logic [7:0]  table_ptr_low;     // table pointer, low byte
  logic [7:0]  table_ptr_high;    // table pointer, high byte
  logic [7:0]  table_high_latch;  // upper byte of last table read
  logic [7:0]  option_map_unlock; // unlock register contents
  csr_unlock_t unl_state;         // pattern detector
  logic [2:0]  map_ticks;         // slow periods since unlock
  logic        fetch_wait;        // program word arrives this cycle

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       setup    = psel & ~penable;
  wire       access   = psel & penable & pready;
  wire       wr_done  = access & pwrite;
  wire [7:0] wbyte    = pwdata[7:0];
  wire       hit_pcl  = (paddr == reg_addr(IDX_PC_LOW));
  wire       hit_tbl  = (paddr == reg_addr(IDX_TBL_LOW));
  wire       hit_tbh  = (paddr == reg_addr(IDX_TBL_HIGH));
  wire       hit_lat  = (paddr == reg_addr(IDX_TBL_LATCH));
  wire       hit_st   = (paddr == reg_addr(IDX_STATUS));
  wire       hit_bank = (paddr == reg_addr(IDX_BANK));
  wire       hit_unl  = (paddr == reg_addr(IDX_UNLOCK));
  wire       mapped   = hit_pcl | hit_tbl | hit_tbh | hit_lat |
                        hit_st | hit_bank | hit_unl;

  // write strobes, one per register except the read-only table latch
  wire wr_pcl  = wr_done & hit_pcl;
  wire wr_tbl  = wr_done & hit_tbl;
  wire wr_tbh  = wr_done & hit_tbh;
  wire wr_st   = wr_done & hit_st;
  wire wr_bank = wr_done & hit_bank;
  wire wr_unl  = wr_done & hit_unl;

  // read mux; bytes only leave through the bus, never reg to reg
  wire [7:0] rd_byte =
    hit_pcl  ? pc_low_byte :
    hit_tbl  ? table_ptr_low :
    hit_tbh  ? table_ptr_high :
    hit_lat  ? table_high_latch :
    hit_st   ? status_flags :
    hit_bank ? {BANK_PAD, program_bank_select} :
    hit_unl  ? option_map_unlock : RESET_BYTE;

  // ----------------------------------------------------------------
  // apb answer: one access cycle, no wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? {PAD_ZERO, rd_byte} : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // bank select and branch target
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_bank_select <= 1'b0;
      branch_valid        <= 1'b0;
      branch_target       <= 14'h0000;
    end else begin
      // only bit 0 is stored
      if (wr_bank) begin
        program_bank_select <= wbyte[0];
      end
      branch_valid <= branch_req;
      // bank bit becomes the top target bit
      if (branch_req) begin
        branch_target <= {program_bank_select, branch_addr};
      end
    end
  end

  // ----------------------------------------------------------------
  // low pc jump with its dummy cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_low_byte    <= RESET_BYTE;
      pc_load        <= 1'b0;
      pc_load_target <= RESET_BYTE;
      pc_dummy       <= 1'b0;
    end else begin
      // only the low byte moves, so page stays put
      pc_load  <= wr_pcl;
      pc_dummy <= pc_load;
      if (wr_pcl) begin
        pc_low_byte    <= wbyte;
        pc_load_target <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // unlock pattern detector
  // ----------------------------------------------------------------
  // second value must be the very next bus transfer
  wire pattern_ok = wr_unl & (wbyte == UNLOCK_SECOND) &
                    (unl_state == UNL_SECOND);
  wire first_seen = wr_unl & (wbyte == UNLOCK_FIRST);
  csr_unlock_t next_unl_state;

  always_comb begin
    next_unl_state = unl_state;
    if (wake_event) begin
      next_unl_state = UNL_FIRST;
    end else if (access) begin
      // any other transfer breaks the pattern
      next_unl_state = first_seen ? UNL_SECOND : UNL_FIRST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_state         <= UNL_FIRST;
      option_map_unlock <= RESET_BYTE;
    end else begin
      unl_state <= next_unl_state;
      // wakeup clears even a write in the same cycle
      if (wake_event) begin
        option_map_unlock <= RESET_BYTE;
      end else if (wr_unl) begin
        option_map_unlock <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // mapping window timer
  // ----------------------------------------------------------------
  wire map_expire = option_map_active & lirc_tick &
                    (map_ticks == LIRC_PERIODS - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_map_active <= 1'b0;
      map_ticks         <= 3'h0;
    end else if (pattern_ok) begin
      // fresh pattern starts the count again
      option_map_active <= 1'b1;
      map_ticks         <= 3'h0;
    end else if (map_expire) begin
      option_map_active <= 1'b0;
      map_ticks         <= 3'h0;
    end else if (option_map_active & lirc_tick) begin
      map_ticks <= map_ticks + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // table read
  // ----------------------------------------------------------------
  wire       tbl_go   = table_read_instr | table_read_last_page;
  wire [7:0] tbl_page = table_read_last_page ? LAST_PAGE : table_ptr_high;
  // last page top quarter swaps to option memory
  wire       in_win   = option_map_active & (tbl_page == LAST_PAGE) &
                        (table_ptr_low >= OPT_WIN_BASE);
  wire [15:0] tbl_addr = in_win ? {OPT_PAD, table_ptr_low[5:0]}
                                : {tbl_page, table_ptr_low};

  // pointer registers, written by software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_ptr_low  <= RESET_BYTE;
      table_ptr_high <= RESET_BYTE;
    end else begin
      if (wr_tbl) begin
        table_ptr_low <= wbyte;
      end
      if (wr_tbh) begin
        table_ptr_high <= wbyte;
      end
    end
  end

  // request, then word arrives one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_req        <= 1'b0;
      fetch_option     <= 1'b0;
      fetch_addr       <= 16'h0000;
      fetch_wait       <= 1'b0;
      table_low_valid  <= 1'b0;
      table_low_data   <= RESET_BYTE;
      table_high_latch <= RESET_BYTE;
    end else begin
      fetch_req       <= tbl_go;
      fetch_wait      <= fetch_req;
      table_low_valid <= fetch_wait;
      if (tbl_go) begin
        fetch_addr   <= tbl_addr;
        fetch_option <= in_win;
      end
      // split the word: high kept here, low handed on
      if (fetch_wait) begin
        table_high_latch <= fetch_data[15:8];
        table_low_data   <= fetch_data[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic [7:0] sw_status;   // after a software write
  logic [7:0] alu_status;  // after the alu update
  logic [7:0] next_status; // after system events

  // software cannot touch timeout or power-down
  always_comb begin
    sw_status = status_flags;
    if (wr_st) begin
      sw_status            = wbyte;
      sw_status[ST_WDTO]   = status_flags[ST_WDTO];
      sw_status[ST_PDOWN]  = status_flags[ST_PDOWN];
    end
  end

  // alu flags, applied over a same-cycle write
  csr_flag_calc u_flags (
    .op  (alu_op),
    .opa (alu_a),
    .opb (alu_b),
    .cur (sw_status),
    .nxt (alu_status)
  );

  // system events; timeout set wins over clears
  always_comb begin
    next_status = alu_valid ? alu_status : sw_status;
    if (watchdog_clear_instr) begin
      next_status[ST_PDOWN] = 1'b0;
      next_status[ST_WDTO]  = 1'b0;
    end
    if (halt_instr) begin
      next_status[ST_PDOWN] = 1'b1;
      next_status[ST_WDTO]  = 1'b0;
    end
    if (watchdog_timeout) begin
      next_status[ST_WDTO]  = 1'b1;
    end
  end

  // plain register: no stack copy on call or interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags <= RESET_BYTE;
    end else begin
      status_flags <= next_status;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bank_upper;
    (setup & ~pwrite & hit_bank) |=> (prdata[31:1] == 31'h00000000);
  endproperty
  a_bank_upper: assert property (p_bank_upper)
    else $error("bank register upper bits not zero");

  property p_bank_target;
    branch_req |=> branch_valid &&
      (branch_target[13] == $past(program_bank_select));
  endproperty
  a_bank_target: assert property (p_bank_target)
    else $error("branch target bank mismatch");

  property p_pcl_jump;
    wr_pcl |=> (pc_load && pc_load_target == $past(wbyte)) ##1 pc_dummy;
  endproperty
  a_pcl_jump: assert property (p_pcl_jump)
    else $error("low pc jump or dummy cycle missing");

  property p_table_latch;
    tbl_go |=> fetch_req ##1 fetch_wait ##1
      (table_low_valid && table_high_latch == $past(fetch_data[15:8]));
  endproperty
  a_table_latch: assert property (p_table_latch)
    else $error("table read word not latched");

  property p_unlock_cause;
    $rose(option_map_active) |-> $past(pattern_ok);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause)
    else $error("mapping opened without pattern");

  property p_window;
    (tbl_go && in_win) |=> fetch_option && fetch_addr[15:6] == OPT_PAD;
  endproperty
  a_window: assert property (p_window)
    else $error("option window not substituted");

  property p_expire;
    (map_expire && !pattern_ok) |=> !option_map_active;
  endproperty
  a_expire: assert property (p_expire)
    else $error("mapping did not end after four periods");

  property p_restart;
    pattern_ok |=> option_map_active && map_ticks == 3'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("mapping timer not restarted");

  property p_wake;
    wake_event |=> option_map_unlock == RESET_BYTE && unl_state == UNL_FIRST;
  endproperty
  a_wake: assert property (p_wake)
    else $error("unlock not cleared on wakeup");

  property p_sw_keep;
    (wr_st && !watchdog_clear_instr && !halt_instr && !watchdog_timeout)
      |=> $stable(status_flags[ST_WDTO]) && $stable(status_flags[ST_PDOWN]);
  endproperty
  a_sw_keep: assert property (p_sw_keep)
    else $error("software write changed system flags");

  property p_halt;
    (halt_instr && !watchdog_timeout) |=>
      status_flags[ST_PDOWN] && !status_flags[ST_WDTO];
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt flags wrong");

  property p_sub_chain;
    (alu_valid && alu_op == OP_SUB) |=>
      status_flags[ST_CHAIN] == status_flags[ST_ZERO];
  endproperty
  a_sub_chain: assert property (p_sub_chain)
    else $error("chained zero differs from zero on subtract");

endmodule

// ### csr_pkg.sv
package csr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PC_LOW     = 8'h06;
  localparam logic [7:0] IDX_TBL_LOW    = 8'h07;
  localparam logic [7:0] IDX_TBL_LATCH  = 8'h08;
  localparam logic [7:0] IDX_TBL_HIGH   = 8'h09;
  localparam logic [7:0] IDX_STATUS     = 8'h0A;
  localparam logic [7:0] IDX_BANK       = 8'h0B;
  localparam logic [7:0] IDX_UNLOCK     = 8'h55;
  localparam int         ADDR_W         = 10;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int ST_CARRY  = 0;
  localparam int ST_HALF   = 1;
  localparam int ST_ZERO   = 2;
  localparam int ST_WRAP   = 3;
  localparam int ST_PDOWN  = 4;
  localparam int ST_WDTO   = 5;
  localparam int ST_CHAIN  = 6;
  localparam int ST_SIGNED = 7;

  // ----------------------------------------------------------------
  // values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [23:0] PAD_ZERO      = 24'h000000;
  localparam logic [6:0]  BANK_PAD      = 7'h00;
  localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND = 8'hAA;
  localparam logic [2:0]  LIRC_PERIODS  = 3'h4;
  localparam logic [7:0]  LAST_PAGE     = 8'h3F;
  localparam logic [7:0]  OPT_WIN_BASE  = 8'hC0;
  localparam logic [9:0]  OPT_PAD       = 10'h000;

  // one-hot alu operation classes
  typedef enum logic [6:0] {
    OP_ADD   = 7'h01,
    OP_ADC   = 7'h02,
    OP_SUB   = 7'h04,
    OP_SBC   = 7'h08,
    OP_LOGIC = 7'h10,
    OP_RRC   = 7'h20,
    OP_RLC   = 7'h40
  } csr_alu_op_t;

  // one-hot unlock pattern states
  typedef enum logic [1:0] {
    UNL_FIRST  = 2'h1,
    UNL_SECOND = 2'h2
  } csr_unlock_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// ### csr_flag_calc.sv
`timescale 1ns/10ps
module csr_flag_calc
  import csr_pkg::*;
(
  // operation
  input  wire csr_alu_op_t op,
  input  wire logic [7:0]  opa,
  input  wire logic [7:0]  opb,
  // flags
  input  wire logic [7:0]  cur,
  output logic      [7:0]  nxt
);

  // ----------------------------------------------------------------
  // adder
  // ----------------------------------------------------------------
  logic       is_sub;   // subtract classes invert b
  logic [7:0] opb_eff;  // b as fed to the adder
  logic       cin;      // carry into bit 0
  logic [8:0] sum;      // full result with carry out
  logic [4:0] nib;      // low nibble with its carry
  logic [7:0] low7;     // bits 6..0 with carry into msb

  assign is_sub  = (op == OP_SUB) || (op == OP_SBC);
  assign opb_eff = is_sub ? ~opb : opb;
  // sub takes no borrow in; adc/sbc chain on carry
  assign cin     = (op == OP_SUB) ||
                   (((op == OP_ADC) || (op == OP_SBC)) && cur[ST_CARRY]);
  assign sum     = {1'b0, opa} + {1'b0, opb_eff} + {8'h00, cin};
  assign nib     = {1'b0, opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, cin};
  assign low7    = {1'b0, opa[6:0]} + {1'b0, opb_eff[6:0]} + {7'h00, cin};

  // ----------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    unique case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        nxt[ST_CARRY]  = sum[8];
        nxt[ST_HALF]   = nib[4];
        nxt[ST_ZERO]   = (sum[7:0] == RESET_BYTE);
        nxt[ST_WRAP]   = low7[7] ^ sum[8];
        nxt[ST_SIGNED] = low7[7] ^ sum[8] ^ sum[7];
        if (op == OP_SUB) begin
          nxt[ST_CHAIN] = (sum[7:0] == RESET_BYTE);
        end else if (op == OP_SBC) begin
          nxt[ST_CHAIN] = cur[ST_CHAIN] & (sum[7:0] == RESET_BYTE);
        end
      end
      // logic ops bring their result on opb
      OP_LOGIC: nxt[ST_ZERO]  = (opb == RESET_BYTE);
      OP_RRC:   nxt[ST_CARRY] = opa[0];
      OP_RLC:   nxt[ST_CARRY] = opa[7];
      default:  nxt = cur;
    endcase
  end

endmodule

// ### tb.sv
`timescale 1ns/10ps
module tb
  import csr_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              pclk        = 1'b0;   // 250 mhz bus clock
  logic              presetn     = 1'b0;   // async reset, active low
  logic [ADDR_W-1:0] paddr       = '0;     // apb byte address
  logic              psel        = 1'b0;   // apb select
  logic              penable     = 1'b0;   // apb access phase
  logic              pwrite      = 1'b0;   // apb direction
  logic [31:0]       pwdata      = '0;     // apb write data
  logic              alu_valid   = 1'b0;   // flag update strobe
  csr_alu_op_t       alu_op      = OP_ADD; // operation class
  logic [7:0]        alu_a       = '0;     // first operand
  logic [7:0]        alu_b       = '0;     // second operand
  logic [7:0]        evt         = '0;     // one-cycle core events
  logic [12:0]       branch_addr = 13'h1234; // jump address in bank
  logic [15:0]       fetch_data  = 16'h9A3C; // program word returned
  logic [31:0]       prdata;               // apb read data
  logic              pready;               // apb ready
  logic              pslverr;              // apb error
  logic              branch_valid;         // branch target valid
  logic [13:0]       branch_target;        // bank plus address
  logic              program_bank_select;  // bank bit
  logic              pc_load;              // low pc jump
  logic [7:0]        pc_load_target;       // jump target
  logic              pc_dummy;             // dummy cycle
  logic              fetch_req;            // table fetch
  logic              fetch_option;         // option memory selected
  logic [15:0]       fetch_addr;           // table fetch address
  logic              table_low_valid;      // low byte ready
  logic [7:0]        table_low_data;       // low byte
  logic              option_map_active;    // mapping window open
  logic [7:0]        status_flags;         // status register
  logic [31:0]       v;                    // read-back scratch
  logic              e;                    // error scratch
  int                n_errors    = 0;      // mismatches
  int                comparisons = 0;      // compares made

  // flag-update rows: operation, operands, compare mask, expected flags
  typedef struct packed {
    csr_alu_op_t op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  m;
    logic [7:0]  x;
  } csr_tb_row_t;
  csr_tb_row_t rows [12] = '{
    '{OP_ADD, 8'h80, 8'h80, 8'h8F, 8'h8D}, '{OP_ADD, 8'h0F, 8'h01, 8'h8F, 8'h02},
    '{OP_ADD, 8'h7F, 8'h01, 8'h8F, 8'h0A}, '{OP_SUB, 8'h00, 8'h01, 8'hCF, 8'h80},
    '{OP_SUB, 8'h80, 8'h01, 8'hCF, 8'h89}, '{OP_SUB, 8'h05, 8'h05, 8'hCF, 8'h47},
    '{OP_SBC, 8'h03, 8'h03, 8'hCF, 8'h47}, '{OP_SBC, 8'h03, 8'h02, 8'hCF, 8'h03},
    '{OP_SBC, 8'h00, 8'h00, 8'hCF, 8'h07}, '{OP_LOGIC, 8'h12, 8'h00, 8'h44, 8'h04},
    '{OP_RRC, 8'h01, 8'h01, 8'h01, 8'h01}, '{OP_RLC, 8'h7F, 8'h7F, 8'h01, 8'h00}};

  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  csr_special_regs i_csr_special_regs (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .alu_valid, .alu_op, .alu_a, .alu_b,
    .watchdog_clear_instr(evt[0]), .halt_instr(evt[1]),
    .watchdog_timeout(evt[2]), .wake_event(evt[3]), .lirc_tick(evt[4]),
    .branch_req(evt[5]), .branch_addr, .branch_valid, .branch_target,
    .program_bank_select, .pc_load, .pc_load_target, .pc_dummy,
    .table_read_instr(evt[6]), .table_read_last_page(evt[7]), .fetch_data,
    .fetch_req, .fetch_option, .fetch_addr, .table_low_valid,
    .table_low_data, .option_map_active, .status_flags);

  // free-running clock
  always #2 pclk = ~pclk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      n_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, v, e);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, v, e);
    check(v, {24'h000000, exp});
  endtask

  // pulse the chosen core events for one cycle, then let outputs land
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    evt <= m;
    @(posedge pclk);
    evt <= 8'h00;
    #1;
  endtask

  // hang guard
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1 check(32'({status_flags[5:4], option_map_active}), 32'h0);
    rdchk(IDX_BANK, 8'h00);
    rdchk(IDX_UNLOCK, 8'h00);
    // flag rows
    foreach (rows[i]) begin
      @(posedge pclk);
      alu_valid <= 1'b1;
      alu_op <= rows[i].op;
      alu_a <= rows[i].a;
      alu_b <= rows[i].b;
      @(posedge pclk);
      alu_valid <= 1'b0;
      #1 check(32'(status_flags & rows[i].m), 32'(rows[i].x));
    end
    // bank select and branch target
    wr(IDX_BANK, 8'hFF);
    rdchk(IDX_BANK, 8'h01);
    pulse(8'h20);
    check(32'({program_bank_select, branch_target}), 32'h7234);
    wr(IDX_BANK, 8'h00);
    pulse(8'h20);
    check(32'({branch_valid, branch_target}), 32'h5234);
    // unmapped place is refused
    apb(1'b0, 8'h30, 8'h00, v, e);
    check(32'({e, v[7:0]}), 32'h100);
    // low pc jump with dummy cycle
    // write lands at the access edge; look once outputs have settled
    wr(IDX_PC_LOW, 8'h5A);
    #1 check(32'({pc_load, pc_load_target}), 32'h15A);
    @(posedge pclk);
    #1 check(32'(pc_dummy), 32'h1);
    // system flags
    pulse(8'h02);
    check(32'(status_flags[5:4]), 32'h1);
    pulse(8'h04);
    check(32'(status_flags[5:4]), 32'h3);
    wr(IDX_STATUS, 8'h00);
    rdchk(IDX_STATUS, 8'h30);
    wr(IDX_STATUS, 8'hCF);
    rdchk(IDX_STATUS, 8'hFF);
    pulse(8'h01);
    check(32'(status_flags[5:4]), 32'h0);
    pulse(8'h04);
    pulse(8'h02);
    check(32'(status_flags[5:4]), 32'h1);
    // option mapping window and its timer
    wr(IDX_TBL_LOW, 8'hC5);
    wr(IDX_TBL_HIGH, 8'h3F);
    // no interrupt traffic between the two pattern writes
    wr(IDX_UNLOCK, UNLOCK_FIRST);
    wr(IDX_UNLOCK, UNLOCK_SECOND);
    @(posedge pclk);
    #1 check(32'(option_map_active), 32'h1);
    pulse(8'h40);
    check(32'({fetch_req, fetch_option, fetch_addr}), 32'h30005);
    repeat (3) pulse(8'h10);
    wr(IDX_UNLOCK, UNLOCK_FIRST);
    wr(IDX_UNLOCK, UNLOCK_SECOND);
    repeat (3) pulse(8'h10);
    check(32'(option_map_active), 32'h1);
    pulse(8'h10);
    @(posedge pclk);
    #1 check(32'(option_map_active), 32'h0);
    pulse(8'h80);
    check(32'({fetch_option, fetch_addr}), 32'h3FC5);
    repeat (2) @(posedge pclk);
    #1 check(32'({table_low_valid, table_low_data}), 32'h13C);
    rdchk(IDX_TBL_LATCH, 8'h9A);
    // broken pattern and wake
    wr(IDX_UNLOCK, UNLOCK_FIRST);
    wr(IDX_UNLOCK, 8'h11);
    wr(IDX_UNLOCK, UNLOCK_SECOND);
    @(posedge pclk);
    #1 check(32'(option_map_active), 32'h0);
    wr(IDX_UNLOCK, UNLOCK_FIRST);
    pulse(8'h08);
    rdchk(IDX_UNLOCK, 8'h00);
    tally_and_finish();
  end
endmodule
